// File: common/tmbt_map.svh
// Named constants for the touch matrix burst timing block: timing, map and reset values.
`ifndef TMBT_MAP_SVH
`define TMBT_MAP_SVH

// Clock rate and the derived microsecond divider.
`define TMBT_CLK_HZ 10000000
`define TMBT_HZ_PER_MHZ 1000000
`define TMBT_US_CYC (`TMBT_CLK_HZ / `TMBT_HZ_PER_MHZ)
`define TMBT_US_PER_MS 1000
// Clocks of a burst slot already spent when the divider restarts, so a slot is whole microseconds.
`define TMBT_US_LEAD 7'h03

// Burst timing figures in their own units.
`define TMBT_BLEN_MAX 7'h40
`define TMBT_BLEN_RST 7'h10
`define TMBT_GAP_MIN_US 4'h1
`define TMBT_GAP_MAX_US 4'hA
`define TMBT_GAP_RST_US 4'h1
`define TMBT_SPACE0_US 500
`define TMBT_SPACE1_MS 1
`define TMBT_SPACE2_MS 2
`define TMBT_CONV_MAX 16'hFFFF

// Startup and calibration figures.
`define TMBT_BOOT_MS 70
`define TMBT_FIRST_MS 2000
`define TMBT_CAL0_MS 100
`define TMBT_CAL1_MS 150
`define TMBT_CAL2_MS 300
`define TMBT_CAL_SCANS 4'h9
`define TMBT_CAL_TRIES 3'h5
`define TMBT_STRAP_CYC 3'h4
`define TMBT_LAST_KEY 4'hF

// Register byte addresses.
`define TMBT_A_CTRL 8'h00
`define TMBT_A_PULSE 8'h04
`define TMBT_A_STATUS 8'h08
`define TMBT_A_CALMASK 8'h0C
`define TMBT_A_ERRMASK 8'h10
`define TMBT_A_RESULT 8'h14
`define TMBT_A_BLEN_BASE 8'h40
`define TMBT_A_BLEN_MASK 8'hC0

// Field positions.
`define TMBT_CTRL_RST_BIT 0
`define TMBT_CTRL_SP_LSB 1
`define TMBT_CTRL_SP_MSB 2

// Bus answers.
`define TMBT_RESP_OKAY 2'h0
`define TMBT_RESP_SLVERR 2'h2

`endif

// File: common/tmbt_pkg.sv
// Types shared by the touch matrix burst timing block.
package tmbt_pkg;

  typedef enum {
    ST_STRAP, ST_BOOT, ST_SLOT, ST_PULSE, ST_GAP, ST_CONV, ST_WAIT
  } tmbt_state_t;

  typedef enum logic [1:0] {
    SP_500US = 2'h0,
    SP_1MS = 2'h1,
    SP_2MS = 2'h2
  } tmbt_spacing_t;

endpackage

// File: verilog/tmbt_usdiv.sv
// Microsecond enable divider with a synchronous restart.
`timescale 1ns/1ns
`include "tmbt_map.svh"

module tmbt_usdiv (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Restart and tick
  input wire logic clr,
  output logic tick
);

  logic [6:0] cnt;

  // Count clock cycles and pulse once per microsecond.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 7'h00;
      tick <= 1'b0;
    end else if (clr) begin
      cnt <= `TMBT_US_LEAD; // The restart comes late, so the first microsecond is shortened.
      tick <= 1'b0;
    end else if (cnt == 7'(`TMBT_US_CYC - 1)) begin
      cnt <= 7'h00;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 7'h01;
      tick <= 1'b0;
    end
  end

endmodule

// File: verilog/tmbt_keymem.sv
// Per-key burst length store with one write port and two registered read ports.
`timescale 1ns/1ns
`include "tmbt_map.svh"

module tmbt_keymem (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Write port
  input wire logic wen,
  input wire logic [3:0] waddr,
  input wire logic [6:0] wdata,
  // Read ports
  input wire logic [3:0] raddrA,
  output logic [6:0] rdataA,
  input wire logic [3:0] raddrB,
  output logic [6:0] rdataB
);

  logic [6:0] mem [16];

  // Store one length per key.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 16; i++) begin
        mem[i] <= `TMBT_BLEN_RST;
      end
    end else if (wen) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read data.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdataA <= `TMBT_BLEN_RST;
      rdataB <= `TMBT_BLEN_RST;
    end else begin
      rdataA <= mem[raddrA];
      rdataB <= mem[raddrB];
    end
  end

endmodule

// File: verilog/tmbt_top.sv
// Burst acquisition timing, startup and calibration control for a 16-key touch matrix.
`timescale 1ns/1ns
`include "tmbt_map.svh"

module tmbt_top import tmbt_pkg::*; #(
  parameter int SPACE0_US = `TMBT_SPACE0_US,
  parameter int SPACE1_US = `TMBT_SPACE1_MS * `TMBT_US_PER_MS,
  parameter int SPACE2_US = `TMBT_SPACE2_MS * `TMBT_US_PER_MS,
  parameter int BOOT_US = `TMBT_BOOT_MS * `TMBT_US_PER_MS,
  parameter int FIRST_US = `TMBT_FIRST_MS * `TMBT_US_PER_MS,
  parameter int CAL0_US = `TMBT_CAL0_MS * `TMBT_US_PER_MS,
  parameter int CAL1_US = `TMBT_CAL1_MS * `TMBT_US_PER_MS,
  parameter int CAL2_US = `TMBT_CAL2_MS * `TMBT_US_PER_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // AXI4-Lite write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Matrix drive, conversion and strap pins
  output logic [3:0] xDrive,
  output logic [3:0] yGate,
  output logic [3:0] yClamp,
  output logic [3:0] rampEn,
  input wire logic rampCmp,
  input wire logic firstPowerUp,
  // Status levels
  output logic commReady,
  output logic calBusy,
  output logic keyError
);

  logic softRst;
  logic rstIntN;
  logic usTick;
  logic cmpS1, cmpS2, cmpS3, cmpLvl;
  logic strS1, strS2, strS3, strLvl;
  tmbt_state_t state;
  logic [2:0] strapCnt;
  logic [21:0] bootCnt, bootLimit;
  logic [3:0] key, keyRd;
  logic [6:0] blenRd, blenRdB, blen, pulseCnt;
  logic [6:0] gapCnt;
  logic [13:0] slotCnt, spaceUs;
  logic [15:0] convCnt, result;
  logic [3:0] resKey;
  logic convDone, convBad, bootDone, scanDone;
  tmbt_spacing_t spacing;
  logic [3:0] gapUs;
  logic [15:0] calibrating, keyErr, failSeen;
  logic [2:0] tries [16];
  logic [3:0] calScans;
  logic [21:0] calUs, calLimit;
  logic awHeld, wHeld, doWrite, rstCmdPend;
  logic [7:0] awAddrQ, arAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic [1:0] arPhase;
  logic next_awHeld, next_wHeld, next_bvalid, next_rvalid;
  logic [1:0] next_arPhase;
  logic [31:0] rdMux;
  logic rdMapped, wrMapped, blenWr;
  logic [6:0] blenVal;

  // The reset command drops the internal reset for one cycle, as the pin does.
  assign rstIntN = rstn & ~softRst;

  // Microsecond enable; restarted at each burst so the slot is cycle exact.
  tmbt_usdiv u_div (
    .clk(clk),
    .rstn(rstIntN),
    .clr(state == ST_SLOT),
    .tick(usTick)
  );

  // While waiting the length of the next key is read, as read data arrive a clock late.
  assign keyRd = (state == ST_WAIT) ? key + 4'h1 : key;

  // Per-key burst length store.
  tmbt_keymem u_mem (
    .clk(clk),
    .rstn(rstIntN),
    .wen(blenWr),
    .waddr(awAddrQ[5:2]),
    .wdata(blenVal),
    .raddrA(keyRd),
    .rdataA(blenRd),
    .raddrB(arAddrQ[5:2]),
    .rdataB(blenRdB)
  );

  // Comparator pin synchroniser; a change counts when stages two and three agree.
  always_ff @(posedge clk or negedge rstIntN) begin
    if (!rstIntN) begin
      {cmpS1, cmpS2, cmpS3, cmpLvl} <= 4'h0;
    end else begin
      cmpS1 <= rampCmp;
      cmpS2 <= cmpS1;
      cmpS3 <= cmpS2;
      if (cmpS2 == cmpS3) begin
        cmpLvl <= cmpS3;
      end
    end
  end

  // First power-up strap synchroniser, read only after the release.
  always_ff @(posedge clk or negedge rstIntN) begin
    if (!rstIntN) begin
      {strS1, strS2, strS3, strLvl} <= 4'h0;
    end else begin
      strS1 <= firstPowerUp;
      strS2 <= strS1;
      strS3 <= strS2;
      if (strS2 == strS3) begin
        strLvl <= strS3;
      end
    end
  end

  // Burst spacing and calibration time for the current setting.
  always_comb begin
    unique case (spacing)
      SP_500US: begin
        spaceUs = 14'(SPACE0_US);
        calLimit = 22'(CAL0_US);
      end
      SP_1MS: begin
        spaceUs = 14'(SPACE1_US);
        calLimit = 22'(CAL1_US);
      end
      default: begin
        spaceUs = 14'(SPACE2_US);
        calLimit = 22'(CAL2_US);
      end
    endcase
  end

  // Startup wait and the key burst sequencer.
  always_ff @(posedge clk or negedge rstIntN) begin
    if (!rstIntN) begin
      state <= ST_STRAP;
      strapCnt <= 3'h0;
      bootCnt <= 22'h0;
      bootLimit <= 22'h0;
      commReady <= 1'b0;
      bootDone <= 1'b0;
      key <= 4'h0;
      blen <= 7'h0;
      pulseCnt <= 7'h0;
      gapCnt <= 7'h0;
      slotCnt <= 14'h0;
      convCnt <= 16'h0;
      result <= 16'h0;
      resKey <= 4'h0;
      convDone <= 1'b0;
      convBad <= 1'b0;
      scanDone <= 1'b0;
      xDrive <= 4'h0;
      yGate <= 4'h0;
      yClamp <= 4'hF;
      rampEn <= 4'h0;
    end else begin
      bootDone <= 1'b0;
      convDone <= 1'b0;
      scanDone <= 1'b0;
      if (usTick) begin
        slotCnt <= slotCnt + 14'h1;
      end
      unique case (state)
        ST_STRAP: begin
          strapCnt <= strapCnt + 3'h1;
          if (strapCnt == `TMBT_STRAP_CYC) begin
            bootLimit <= strLvl ? 22'(FIRST_US) : 22'(BOOT_US);
            state <= ST_BOOT;
          end
        end
        ST_BOOT: begin
          if (usTick) begin
            bootCnt <= bootCnt + 22'h1;
          end
          if (bootCnt == bootLimit) begin
            commReady <= 1'b1;
            bootDone <= 1'b1;
            key <= 4'h0;
            state <= ST_SLOT;
          end
        end
        ST_SLOT: begin
          slotCnt <= 14'h0;
          pulseCnt <= 7'h0;
          blen <= (blenRd > `TMBT_BLEN_MAX) ? `TMBT_BLEN_MAX : blenRd;
          if (blenRd == 7'h0) begin
            state <= ST_WAIT;
          end else begin
            xDrive <= 4'h1 << key[1:0];
            yGate <= 4'h1 << key[3:2];
            yClamp <= ~(4'h1 << key[3:2]);
            state <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          // X falls after one clock; the gate drops and all Y lines are clamped on the same edge.
          xDrive <= 4'h0;
          yGate <= 4'h0;
          yClamp <= 4'hF;
          pulseCnt <= pulseCnt + 7'h1;
          gapCnt <= 7'h1;
          if (pulseCnt + 7'h1 == blen) begin
            convCnt <= 16'h0;
            rampEn <= 4'h1 << key[3:2];
            state <= ST_CONV;
          end else begin
            state <= ST_GAP;
          end
        end
        ST_GAP: begin
          gapCnt <= gapCnt + 7'h1;
          if (gapCnt == 7'(gapUs * `TMBT_US_CYC) - 7'h1) begin
            xDrive <= 4'h1 << key[1:0];
            yGate <= 4'h1 << key[3:2];
            yClamp <= ~(4'h1 << key[3:2]);
            state <= ST_PULSE;
          end
        end
        ST_CONV: begin
          convCnt <= convCnt + 16'h1;
          if (cmpLvl || convCnt == `TMBT_CONV_MAX) begin
            rampEn <= 4'h0;
            result <= convCnt;
            resKey <= key;
            convBad <= (convCnt == `TMBT_CONV_MAX) || (convCnt == 16'h0);
            convDone <= 1'b1;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (slotCnt >= spaceUs) begin
            key <= key + 4'h1;
            scanDone <= (key == `TMBT_LAST_KEY);
            state <= ST_SLOT;
          end
        end
      endcase
    end
  end

  // Calibration cycles, retries and key error flags.
  always_ff @(posedge clk or negedge rstIntN) begin
    if (!rstIntN) begin
      calibrating <= 16'h0;
      keyErr <= 16'h0;
      failSeen <= 16'h0;
      calScans <= 4'h0;
      calUs <= 22'h0;
      for (int i = 0; i < 16; i++) begin
        tries[i] <= 3'h0;
      end
    end else if (bootDone) begin
      calibrating <= 16'hFFFF;
    end else if (|calibrating) begin
      if (usTick && calUs < calLimit) begin
        calUs <= calUs + 22'h1;
      end
      if (scanDone && calScans < `TMBT_CAL_SCANS) begin
        calScans <= calScans + 4'h1;
      end
      if (calUs >= calLimit && calScans >= `TMBT_CAL_SCANS) begin
        calUs <= 22'h0;
        calScans <= 4'h0;
        failSeen <= 16'h0;
        for (int i = 0; i < 16; i++) begin
          if (calibrating[i] && failSeen[i]) begin
            tries[i] <= tries[i] + 3'h1;
            if (tries[i] + 3'h1 == `TMBT_CAL_TRIES) begin
              keyErr[i] <= 1'b1;
              calibrating[i] <= 1'b0;
            end
          end else begin
            calibrating[i] <= 1'b0;
          end
        end
      end
      // A failure in the closing cycle wins over the clear and is kept.
      if (convDone && convBad && calibrating[resKey]) begin
        failSeen[resKey] <= 1'b1;
      end
    end
  end

  // Status levels on the pins.
  always_ff @(posedge clk or negedge rstIntN) begin
    if (!rstIntN) begin
      calBusy <= 1'b0;
      keyError <= 1'b0;
    end else begin
      calBusy <= |calibrating;
      keyError <= |keyErr;
    end
  end

  // Write address decode and the value written to a key length.
  assign blenWr = doWrite && wStrbQ[0] && ((awAddrQ & `TMBT_A_BLEN_MASK) == `TMBT_A_BLEN_BASE);
  assign blenVal = (wDataQ[6:0] > `TMBT_BLEN_MAX) ? `TMBT_BLEN_MAX : wDataQ[6:0];
  assign wrMapped = ((awAddrQ & `TMBT_A_BLEN_MASK) == `TMBT_A_BLEN_BASE) ||
      (awAddrQ == `TMBT_A_CTRL) || (awAddrQ == `TMBT_A_PULSE);
  assign doWrite = awHeld && wHeld && !bvalid;

  // Next values of the bus handshake state.
  always_comb begin
    next_awHeld = (awvalid && awready) ? 1'b1 : (doWrite ? 1'b0 : awHeld);
    next_wHeld = (wvalid && wready) ? 1'b1 : (doWrite ? 1'b0 : wHeld);
    next_bvalid = doWrite ? 1'b1 : ((bvalid && bready) ? 1'b0 : bvalid);
    next_arPhase = (arvalid && arready) ? 2'h1 : ((arPhase == 2'h0) ? 2'h0 : arPhase + 2'h1);
    if (arPhase == 2'h2) begin
      next_arPhase = 2'h0;
    end
    next_rvalid = (arPhase == 2'h2) ? 1'b1 : ((rvalid && rready) ? 1'b0 : rvalid);
  end

  // Write channels; nothing is taken before the startup wait ends.
  always_ff @(posedge clk or negedge rstIntN) begin
    if (!rstIntN) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= 8'h00;
      wDataQ <= 32'h0;
      wStrbQ <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `TMBT_RESP_OKAY;
    end else begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      bvalid <= next_bvalid;
      awready <= commReady && !next_awHeld && !next_bvalid;
      wready <= commReady && !next_wHeld && !next_bvalid;
      if (awvalid && awready) begin
        awAddrQ <= awaddr;
      end
      if (wvalid && wready) begin
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (doWrite) begin
        bresp <= wrMapped ? `TMBT_RESP_OKAY : `TMBT_RESP_SLVERR;
      end
    end
  end

  // Software settings and the reset command.
  always_ff @(posedge clk or negedge rstIntN) begin
    if (!rstIntN) begin
      spacing <= SP_500US;
      gapUs <= `TMBT_GAP_RST_US;
      rstCmdPend <= 1'b0;
    end else if (doWrite && wStrbQ[0]) begin
      if (awAddrQ == `TMBT_A_CTRL) begin
        rstCmdPend <= wDataQ[`TMBT_CTRL_RST_BIT];
        if (wDataQ[`TMBT_CTRL_SP_MSB:`TMBT_CTRL_SP_LSB] != 2'h3) begin
          spacing <= tmbt_spacing_t'(wDataQ[`TMBT_CTRL_SP_MSB:`TMBT_CTRL_SP_LSB]);
        end
      end
      if (awAddrQ == `TMBT_A_PULSE) begin
        gapUs <= (wDataQ[3:0] < `TMBT_GAP_MIN_US) ? `TMBT_GAP_MIN_US :
            ((wDataQ[3:0] > `TMBT_GAP_MAX_US) ? `TMBT_GAP_MAX_US : wDataQ[3:0]);
      end
    end
  end

  // The reset command fires once its write answer has been taken.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      softRst <= 1'b0;
    end else begin
      softRst <= rstCmdPend && bvalid && bready && !softRst;
    end
  end

  // Read data selection.
  always_comb begin
    rdMapped = 1'b1;
    rdMux = 32'h0;
    if ((arAddrQ & `TMBT_A_BLEN_MASK) == `TMBT_A_BLEN_BASE) begin
      rdMux = {25'h0, blenRdB};
    end else begin
      unique case (arAddrQ)
        `TMBT_A_CTRL: rdMux = {29'h0, spacing, 1'b0};
        `TMBT_A_PULSE: rdMux = {28'h0, gapUs};
        `TMBT_A_STATUS: rdMux = {29'h0, |keyErr, |calibrating, commReady};
        `TMBT_A_CALMASK: rdMux = {16'h0, calibrating};
        `TMBT_A_ERRMASK: rdMux = {16'h0, keyErr};
        `TMBT_A_RESULT: rdMux = {12'h0, resKey, result};
        default: rdMapped = 1'b0;
      endcase
    end
  end

  // Read channels; the answer comes two edges after the address is taken.
  always_ff @(posedge clk or negedge rstIntN) begin
    if (!rstIntN) begin
      arPhase <= 2'h0;
      arAddrQ <= 8'h00;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `TMBT_RESP_OKAY;
    end else begin
      arPhase <= next_arPhase;
      rvalid <= next_rvalid;
      arready <= commReady && next_arPhase == 2'h0 && !next_rvalid;
      if (arvalid && arready) begin
        arAddrQ <= araddr;
      end
      if (arPhase == 2'h2) begin
        rdata <= rdMux;
        rresp <= rdMapped ? `TMBT_RESP_OKAY : `TMBT_RESP_SLVERR;
      end
    end
  end

endmodule

// File: bench/tmbt_checker.sv
// Assertions on the pins of the touch matrix burst timing top module.
`timescale 1ns/1ns
module tmbt_checker #(
  parameter int SPACE0_US = 500,
  parameter int BOOT_US = 70000,
  parameter int FIRST_US = 2000000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bus readies
  input wire logic awready,
  input wire logic wready,
  input wire logic arready,
  // Matrix and strap pins
  input wire logic [3:0] xDrive,
  input wire logic [3:0] yGate,
  input wire logic [3:0] yClamp,
  input wire logic [3:0] rampEn,
  input wire logic firstPowerUp,
  // Status levels
  input wire logic commReady,
  input wire logic calBusy
);
  // One scan holds sixteen slots of the reset burst spacing.
  localparam int SCAN = 16 * SPACE0_US * 10;
  int lowCnt;
  int calCnt;
  int bootCyc;
  logic [3:0] lastGate;
  logic [3:0] lastKey;
  logic [3:0] keyNow;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Key index on the pins, column above row, and the startup wait for the strap.
  assign keyNow = {yGate[3] | yGate[2], yGate[3] | yGate[1], xDrive[3] | xDrive[2], xDrive[3] | xDrive[1]};
  assign bootCyc = (firstPowerUp ? FIRST_US : BOOT_US) * 10;
  // Clocks spent with the bus closed and clocks spent calibrating.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lowCnt <= 0;
      calCnt <= 0;
    end else begin
      lowCnt <= commReady ? 0 : lowCnt + 1;
      calCnt <= calBusy ? calCnt + 1 : 0;
    end
  end
  // Last pulsed column and key; a restart puts the scan just before key zero.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lastGate <= 4'h0;
      lastKey <= 4'hF;
    end else if (!commReady) begin
      lastKey <= 4'hF;
    end else if (|xDrive) begin
      lastGate <= yGate;
      lastKey <= keyNow;
    end
  end
  // Nine quiet clocks follow every pulse, the shortest pulse spacing.
  sequence quiet_gap;
    (xDrive == 4'h0) [*8] ##1 (xDrive == 4'h0);
  endsequence
  a_pulse_single: assert property ((|xDrive) |=> (xDrive == 4'h0))
    else $error("drive pulse longer than one clock");
  a_gate_dwell: assert property (((|xDrive) == (|yGate)) && $onehot0(xDrive) && $onehot0(yGate))
    else $error("gate and drive not paired");
  a_clamp_free: assert property (yClamp == ~yGate)
    else $error("clamp not released on gated column only");
  a_gap_min: assert property ($rose(|xDrive) |=> quiet_gap)
    else $error("pulses closer than one microsecond");
  a_ramp_column: assert property ($rose(|rampEn) |-> rampEn == lastGate)
    else $error("ramp on wrong column");
  a_conv_quiet: assert property ((|rampEn) |-> xDrive == 4'h0)
    else $error("pulse during conversion");
  a_bus_closed: assert property (!commReady |-> !(awready || wready || arready))
    else $error("bus open before startup ends");
  a_boot_wait: assert property ($rose(commReady) |-> lowCnt >= bootCyc && lowCnt <= bootCyc + 20)
    else $error("startup wait wrong length");
  a_cal_begins: assert property ($rose(commReady) |-> ##[1:2] calBusy)
    else $error("calibration did not start");
  a_cal_length: assert property ($fell(calBusy) && commReady |-> calCnt >= 8 * SCAN && calCnt <= 11 * SCAN)
    else $error("calibration length wrong");
  a_scan_order: assert property (calBusy && (|xDrive) && keyNow != lastKey |-> keyNow == lastKey + 4'h1)
    else $error("scan order broken");
endmodule

bind tmbt_top tmbt_checker #(.SPACE0_US(SPACE0_US), .BOOT_US(BOOT_US), .FIRST_US(FIRST_US)) chk (
  .clk(clk), .rstn(rstn), .awready(awready), .wready(wready), .arready(arready),
  .xDrive(xDrive), .yGate(yGate), .yClamp(yClamp), .rampEn(rampEn),
  .firstPowerUp(firstPowerUp), .commReady(commReady), .calBusy(calBusy));

// File: bench/tmbt_matrix_model.sv
// Behavioural model of the key matrix and ramp comparator beside the burst timing block.
`timescale 1ns/1ns
module tmbt_matrix_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Ramp enable from the block and ramp speed from the bench
  input wire logic [3:0] rampEn,
  input wire logic slowRamp,
  // Comparator output
  output logic rampCmp
);
  logic [7:0] rampCnt;
  // The ramp runs only while enabled; a slow ramp still fits a short slot.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rampCnt <= 8'h00;
      rampCmp <= 1'b0;
    end else if (|rampEn) begin
      rampCnt <= rampCnt + 8'h01;
      rampCmp <= rampCnt >= (slowRamp ? 8'h1E : 8'h05);
    end else begin
      rampCnt <= 8'h00;
      rampCmp <= 1'b0;
    end
  end
endmodule

// File: bench/tmbt_top_bench.sv
// Self-checking bench for the touch matrix burst timing block.
`timescale 1ns/1ns
`include "tmbt_map.svh"
module tmbt_top_bench;
  localparam int SP0 = 20;
  localparam int CAL = 50;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic firstPowerUp = 1'b0, slowRamp = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rampCmp, commReady, calBusy, keyError;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic [3:0] xDrive, yGate, yClamp, rampEn;
  logic [4:0] curKey = 5'h10;
  logic [4:0] keyNow;
  int n_fail = 0, checks_done = 0, run = 0, since = 0, gapCnt = 0, span = 0, pulseSpan = 0;
  int burstCnt [17];
  int sp [3] = '{SP0 * 10, 300, 800};
  // The widest slot holds a 64-pulse burst and its conversion.
  tmbt_top #(.SPACE0_US(SP0), .SPACE1_US(30), .SPACE2_US(80), .BOOT_US(20), .FIRST_US(40),
    .CAL0_US(CAL), .CAL1_US(CAL), .CAL2_US(CAL)) dut (
    .clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .xDrive(xDrive),
    .yGate(yGate), .yClamp(yClamp), .rampEn(rampEn), .rampCmp(rampCmp),
    .firstPowerUp(firstPowerUp), .commReady(commReady), .calBusy(calBusy), .keyError(keyError));
  tmbt_matrix_model model (.clk(clk), .rstn(rstn), .rampEn(rampEn), .slowRamp(slowRamp),
    .rampCmp(rampCmp));
  // Clock of 100 ns period.
  initial begin
    forever #50 clk = ~clk;
  end
  // Counts a comparison and reports a mismatch.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One write; address and data are each released once taken.
  task wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && t < 500);
    rsp = bresp;
    bready <= 1'b0;
    check(32'(t < 500), 32'h1);
  endtask
  // One read; the answer is taken at the handshake edge.
  task rdr(input logic [7:0] a);
    int t;
    t = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && t < 500);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    check(32'(t < 500), 32'h1);
  endtask
  // Waits under a bound for a status level.
  task wait_lvl(input bit cal, input logic lvl, input int lim);
    int t;
    t = 0;
    while ((cal ? calBusy : commReady) !== lvl && t < lim) begin
      @(posedge clk);
      t++;
    end
    check(32'(t < lim), 32'h1);
  endtask
  // Watches the pins: pulses per burst, start-to-start span and pulse spacing.
  always @(posedge clk) begin
    since++;
    gapCnt++;
    if (|xDrive) begin
      keyNow = {1'b0, yGate[3] | yGate[2], yGate[3] | yGate[1], xDrive[3] | xDrive[2], xDrive[3] | xDrive[1]};
      if (keyNow != curKey) begin
        burstCnt[curKey] = run;
        span = since;
        since = 0;
        run = 0;
        curKey = keyNow;
      end else pulseSpan = gapCnt;
      run++;
      gapCnt = 0;
    end
  end
  // Prints the verdict and ends the run.
  task final_report;
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    final_report;
  end
  // Main sequence.
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    wait_lvl(0, 1'b1, 2000);
    repeat (3) @(posedge clk);
    check(calBusy, 1'b1);
    rdr(`TMBT_A_CALMASK);
    check(rd, 32'hFFFF);
    rdr(`TMBT_A_CTRL);
    check(rd, 32'h0);
    rdr(`TMBT_A_BLEN_BASE + 8'h0C);
    check(rd, 32'h10);
    rdr(8'h20);
    check({rd[29:0], rsp}, {30'h0, `TMBT_RESP_SLVERR});
    wr(8'h20, 32'h1);
    check(rsp, `TMBT_RESP_SLVERR);
    wait_lvl(1, 1'b0, 40000);
    rdr(`TMBT_A_STATUS);
    check(rd, 32'h1);
    check(keyError, 1'b0);
    for (int s = 0; s < 3; s++) begin
      wr(`TMBT_A_CTRL, 32'(s << 1));
      repeat (1400) @(posedge clk);
      check(32'(span >= sp[s] && span <= sp[s] + 2), 32'h1);
    end
    wr(`TMBT_A_CTRL, 32'h6);
    rdr(`TMBT_A_CTRL);
    check(rd, 32'h4);
    wr(`TMBT_A_PULSE, 32'h0);
    rdr(`TMBT_A_PULSE);
    check(rd, 32'h1);
    wr(`TMBT_A_PULSE, 32'hF);
    rdr(`TMBT_A_PULSE);
    check(rd, 32'hA);
    wr(`TMBT_A_PULSE, 32'h4);
    repeat (1500) @(posedge clk);
    check(pulseSpan, 32'd40);
    wr(`TMBT_A_PULSE, 32'h1);
    wr(`TMBT_A_BLEN_BASE + 8'h14, 32'h1);
    wr(`TMBT_A_BLEN_BASE + 8'h18, 32'd100);
    wr(`TMBT_A_BLEN_BASE + 8'h1C, 32'h0);
    rdr(`TMBT_A_BLEN_BASE + 8'h18);
    check(rd, 32'd64);
    repeat (8000) @(posedge clk);
    foreach (burstCnt[i]) burstCnt[i] = 0;
    repeat (15500) @(posedge clk);
    check(burstCnt[5], 32'd1);
    check(burstCnt[6], 32'd64);
    check(burstCnt[7], 32'd0);
    check(burstCnt[8], 32'd16);
    slowRamp <= 1'b1;
    repeat (2000) @(posedge clk);
    rdr(`TMBT_A_RESULT);
    check(32'(rd[15:0] >= 16'd30 && rd[15:0] <= 16'd40), 32'h1);
    slowRamp <= 1'b0;
    wr(`TMBT_A_PULSE, 32'h5);
    wr(`TMBT_A_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    check(commReady, 1'b0);
    wait_lvl(0, 1'b1, 2000);
    rdr(`TMBT_A_PULSE);
    check(rd, 32'h1);
    rdr(`TMBT_A_BLEN_BASE + 8'h18);
    check(rd, 32'h10);
    check(calBusy, 1'b1);
    rstn <= 1'b0;
    firstPowerUp <= 1'b1;
    repeat (100) @(posedge clk);
    rstn <= 1'b1;
    repeat (300) @(posedge clk);
    check(commReady, 1'b0);
    wait_lvl(0, 1'b1, 1000);
    final_report;
  end
endmodule
